// ---- uvp_pkg.sv ----
// Package with the constants, states and carriers of the EPROM programmer controller.
package uvp_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 14;  // 16384 locations.
	localparam int DATA_W = 8;   // One byte per location.

	// ----------------------------------------------------------------
	// Timing at 250 MHz
	// ----------------------------------------------------------------
	localparam int CLK_MHZ         = 250;  // Clock rate in MHz.
	localparam int PULSE_US        = 100;  // Program pulse width in microseconds.
	localparam int PULSE_CYC       = PULSE_US * CLK_MHZ;  // 25000 cycles.
	localparam int MAX_PULSES      = 10;   // Pulse-and-verify attempts per byte.
	localparam int SETUP_CYC       = 8;    // Settle time for address, data and supplies.
	localparam int READ_CYC        = 8;    // Access wait before sampling the data pins.
	localparam int CNT_W           = 16;   // Width of the delay counter.

	// ----------------------------------------------------------------
	// Command codes on the user port
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		UVP_CMD_READ = 2'h0,  // Plain read at normal supply.
		UVP_CMD_PROG = 2'h1,  // Program one byte with verify and retry.
		UVP_CMD_SIG  = 2'h2,  // Read an identifier byte in signature mode.
		UVP_CMD_NONE = 2'h3   // Reserved, refused.
	} uvp_cmd_t;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		UVP_IDLE   = 3'h0,  // Chip deselected, standby.
		UVP_RSETUP = 3'h1,  // Address applied, waiting for access.
		UVP_PSETUP = 3'h2,  // Program supplies, address and data settling.
		UVP_PULSE  = 3'h3,  // Program strobe low.
		UVP_RELEAS = 3'h4,  // Data drivers released before verify.
		UVP_VERIFY = 3'h5,  // Verify read at raised supply.
		UVP_DONE   = 3'h6   // Result presented for one cycle.
	} uvp_state_t;

	// Pins that go out to the memory device.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;           // Address pins, id_byte_sel is bit 0.
		logic              chip_on_low;    // Chip enable, active low.
		logic              output_on_low;  // Output enable, active low.
		logic              burn_strobe_n;  // Program strobe, active low.
		logic              vpp_raise;      // Raise programming supply.
		logic              vcc_raise;      // Raise core supply.
		logic              id_high_volt_pin;  // Apply identification voltage.
		logic [DATA_W-1:0] data_out;       // Data to drive on data_pins.
		logic              data_oe;        // High while we drive data_pins.
	} uvp_pins_t;

	// Answer toward the user.
	typedef struct packed {
		logic              done;   // One-cycle completion pulse.
		logic              fail;   // Programming gave up after the last pulse.
		logic [DATA_W-1:0] rdata;  // Byte read or verified.
	} uvp_resp_t;

	localparam logic [DATA_W-1:0] ERASED = 8'hff;  // Value of a blank byte.

endpackage

// ---- uvp_delay.sv ----
// Delay counter that raises a flag after a programmed number of cycles.
`timescale 1ns/1ps
module uvp_delay #(
	parameter int W = uvp_pkg::CNT_W
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic         load,   // Start a new count.
	input  wire logic [W-1:0] count,  // Cycles to wait, at least one.
	output logic              expired // High once the count has elapsed.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] left;  // Cycles still to go.
		logic         run;   // Counting is in progress.
	} uvp_dly_t;

	uvp_dly_t st;       // Registered state.
	uvp_dly_t next_st;  // Next state.

	// Load restarts; otherwise count down to zero and stop.
	always_comb begin
		next_st = st;
		if (load) begin
			next_st.left = count - W'(1);
			next_st.run  = 1'b1;
		end else if (st.run) begin
			if (st.left == '0) begin
				next_st.run = 1'b0;
			end else begin
				next_st.left = st.left - W'(1);
			end
		end
	end

	// Clock enable freezes the count.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Expiry is the last counting cycle. It must not look at load: the sequencer
	// raises load in answer to expiry, and gating on it would close a combinational loop.
	assign expired = st.run && (st.left == '0);

endmodule

// ---- uvp_ctrl.sv ----
// Host-side controller that reads, programs and identifies a 16K x 8 EPROM over its pins.
`timescale 1ns/1ps
module uvp_ctrl #(
	parameter int PULSE_CYC  = uvp_pkg::PULSE_CYC,
	parameter int MAX_PULSES = uvp_pkg::MAX_PULSES
) (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       ce,
	input  wire logic                       req_valid,   // Request strobe.
	input  wire logic [1:0]                 req_cmd,     // Command code.
	input  wire logic [uvp_pkg::ADDR_W-1:0] req_addr,    // Byte address.
	input  wire logic [uvp_pkg::DATA_W-1:0] req_wdata,   // Byte to program.
	output logic                            req_ready,   // Idle and able to take a request.
	output uvp_pkg::uvp_resp_t              resp,        // Completion, failure, data.
	output uvp_pkg::uvp_pins_t              pins,        // Memory pins.
	input  wire logic [uvp_pkg::DATA_W-1:0] data_in      // Sampled data_pins.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		uvp_pkg::uvp_state_t          fsm;     // Controller state.
		uvp_pkg::uvp_cmd_t            cmd;     // Command in progress.
		logic [3:0]                   tries;   // Pulses applied to this byte.
		logic                         ready;   // Registered ready.
		uvp_pkg::uvp_resp_t           resp;    // Registered answer.
		uvp_pkg::uvp_pins_t           pins;    // Registered pins.
	} uvp_ctl_t;

	uvp_ctl_t st;       // Registered state.
	uvp_ctl_t next_st;  // Next state.

	logic                        dly_load;   // Start the delay counter.
	logic [uvp_pkg::CNT_W-1:0]   dly_count;  // Delay to load.
	logic                        dly_done;   // Delay elapsed.

	// Pulse counter may exceed the default width when overridden, so it is cut on purpose.
	localparam logic [uvp_pkg::CNT_W-1:0] PULSE_LEN = uvp_pkg::CNT_W'(PULSE_CYC);
	localparam logic [3:0]                TRY_MAX   = 4'(MAX_PULSES);

	// ----------------------------------------------------------------
	// Delay counter shared by every wait
	// ----------------------------------------------------------------
	uvp_delay #(
		.W(uvp_pkg::CNT_W)
	) u_delay (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.load   (dly_load),
		.count  (dly_count),
		.expired(dly_done)
	);

	// Reset pin state: standby, supplies at read level, nothing driven.
	localparam uvp_pkg::uvp_pins_t PINS_IDLE = '{
		addr: '0, chip_on_low: 1'b1, output_on_low: 1'b1, burn_strobe_n: 1'b1,
		vpp_raise: 1'b0, vcc_raise: 1'b0, id_high_volt_pin: 1'b0,
		data_out: '0, data_oe: 1'b0};

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// One process moves the pins through read, program pulse and verify.
	always_comb begin
		next_st        = st;
		next_st.resp.done = 1'b0;
		dly_load       = 1'b0;
		dly_count      = uvp_pkg::CNT_W'(uvp_pkg::SETUP_CYC);
		unique case (st.fsm)
			uvp_pkg::UVP_IDLE: begin
				// Chip deselected keeps the device in standby.
				next_st.pins  = PINS_IDLE;
				next_st.ready = 1'b1;
				if (req_valid && st.ready && req_cmd != uvp_pkg::UVP_CMD_NONE) begin
					next_st.ready = 1'b0;
					next_st.cmd   = uvp_pkg::uvp_cmd_t'(req_cmd);
					next_st.tries = '0;
					next_st.resp.fail = 1'b0;
					next_st.pins.addr = req_addr;  // Any address order.
					dly_load = 1'b1;
					if (req_cmd == uvp_pkg::UVP_CMD_PROG) begin
						// Program mode: raised supplies, output high, chip low.
						next_st.pins.vpp_raise   = 1'b1;
						next_st.pins.vcc_raise   = 1'b1;
						next_st.pins.chip_on_low = 1'b0;
						next_st.pins.data_out    = req_wdata;
						next_st.pins.data_oe     = 1'b1;
						next_st.fsm = uvp_pkg::UVP_PSETUP;
					end else begin
						// Read, or signature read with upper address held low.
						next_st.pins.chip_on_low   = 1'b0;
						next_st.pins.output_on_low = 1'b0;
						if (req_cmd == uvp_pkg::UVP_CMD_SIG) begin
							next_st.pins.addr = {{(uvp_pkg::ADDR_W-1){1'b0}}, req_addr[0]};
							next_st.pins.id_high_volt_pin = 1'b1;
						end
						dly_count = uvp_pkg::CNT_W'(uvp_pkg::READ_CYC);
						next_st.fsm = uvp_pkg::UVP_RSETUP;
					end
				end
			end
			uvp_pkg::UVP_RSETUP: begin
				if (dly_done) begin
					next_st.resp.rdata = data_in;
					next_st.fsm = uvp_pkg::UVP_DONE;
				end
			end
			uvp_pkg::UVP_PSETUP: begin
				// Address and data have been stable for the setup time.
				if (dly_done) begin
					next_st.pins.burn_strobe_n = 1'b0;
					next_st.tries = st.tries + 4'h1;
					dly_load  = 1'b1;
					dly_count = PULSE_LEN;
					next_st.fsm = uvp_pkg::UVP_PULSE;
				end
			end
			uvp_pkg::UVP_PULSE: begin
				if (dly_done) begin
					// Strobe high ends the pulse and inhibits further writes.
					next_st.pins.burn_strobe_n = 1'b1;
					next_st.pins.data_oe = 1'b0;
					dly_load = 1'b1;
					next_st.fsm = uvp_pkg::UVP_RELEAS;
				end
			end
			uvp_pkg::UVP_RELEAS: begin
				if (dly_done) begin
					next_st.pins.output_on_low = 1'b0;  // Verify read.
					dly_load  = 1'b1;
					dly_count = uvp_pkg::CNT_W'(uvp_pkg::READ_CYC);
					next_st.fsm = uvp_pkg::UVP_VERIFY;
				end
			end
			uvp_pkg::UVP_VERIFY: begin
				if (dly_done) begin
					next_st.resp.rdata = data_in;
					next_st.pins.output_on_low = 1'b1;
					if (data_in == st.pins.data_out || st.tries >= TRY_MAX) begin
						// Pass, or give up after the last pulse.
						next_st.resp.fail = (data_in != st.pins.data_out);
						next_st.fsm = uvp_pkg::UVP_DONE;
					end else begin
						// Retry: drive data again before the next pulse.
						next_st.pins.data_oe = 1'b1;
						dly_load = 1'b1;
						next_st.fsm = uvp_pkg::UVP_PSETUP;
					end
				end
			end
			uvp_pkg::UVP_DONE: begin
				// Back to standby and normal supply before any later compare.
				next_st.resp.done = 1'b1;
				next_st.pins = PINS_IDLE;
				next_st.fsm  = uvp_pkg::UVP_IDLE;
			end
			default: begin
				next_st.pins = PINS_IDLE;
				next_st.fsm  = uvp_pkg::UVP_IDLE;
			end
		endcase
	end

	// Clock enable low freezes the whole controller.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{fsm: uvp_pkg::UVP_IDLE, cmd: uvp_pkg::UVP_CMD_READ, tries: 4'h0,
				ready: 1'b0, resp: '0, pins: PINS_IDLE};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign req_ready = st.ready;
	assign resp      = st.resp;
	// One registered pin set can fan out to several devices programmed in parallel.
	assign pins      = st.pins;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Never drive data while the device drives it.
	a_no_bus_fight: assert property (@(posedge clk) disable iff (!resetn)
		!(st.pins.data_oe && !st.pins.output_on_low))
		else $error("data driven while device outputs enabled");

	// A strobe pulse only with chip selected and raised supply.
	a_strobe_mode: assert property (@(posedge clk) disable iff (!resetn)
		!st.pins.burn_strobe_n |-> (!st.pins.chip_on_low && st.pins.output_on_low
		&& st.pins.vpp_raise && st.pins.vcc_raise))
		else $error("program pulse outside programming mode");

	// Data is stable throughout a pulse.
	a_pulse_stable: assert property (@(posedge clk) disable iff (!resetn || !ce)
		(!st.pins.burn_strobe_n && !$past(st.pins.burn_strobe_n)) |->
		($stable(st.pins.data_out) && $stable(st.pins.addr) && st.pins.data_oe))
		else $error("address or data moved during pulse");

	// Never more pulses than allowed.
	a_try_limit: assert property (@(posedge clk) disable iff (!resetn)
		st.tries <= TRY_MAX)
		else $error("too many program pulses");

	// Signature mode holds the upper address low.
	a_sig_addr: assert property (@(posedge clk) disable iff (!resetn)
		st.pins.id_high_volt_pin |-> (st.pins.addr[uvp_pkg::ADDR_W-1:1] == '0))
		else $error("upper address not low in signature mode");

	// Idle means standby at normal supply.
	a_idle_standby: assert property (@(posedge clk) disable iff (!resetn)
		(st.fsm == uvp_pkg::UVP_IDLE) |-> (st.pins.chip_on_low && !st.pins.vpp_raise))
		else $error("idle but not in standby");

	// Done pulse lasts one cycle and returns to idle.
	a_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
		(st.resp.done && ce) |=> !st.resp.done)
		else $error("done held longer than one cycle");

	// A pulse starts only after verify has failed or on the first try.
	a_pulse_start: assert property (@(posedge clk) disable iff (!resetn)
		$fell(st.pins.burn_strobe_n) |-> (st.tries >= 4'h1 && st.pins.output_on_low))
		else $error("pulse started in wrong state");

endmodule

// ---- uvp_eprom_model.sv ----
// Behavioural model of the 16K x 8 memory device that the controller drives.
`timescale 1ns/1ps
module uvp_eprom_model #(
	parameter logic [7:0] MFG_ID = 8'ha5,  // Arbitrary value.
	parameter logic [7:0] DEV_ID = 8'h4e   // Arbitrary value.
) (
	input  wire logic         clk,
	input  uvp_pkg::uvp_pins_t pins,
	input  wire logic [3:0]   pulse_need,  // Pulses before a byte takes.
	output logic [7:0]        data_in,
	output int                pulses,
	output int                width,
	output int                bad
);
	// --------------------------------------------------------
	// State
	// --------------------------------------------------------
	logic [7:0]  mem [0:16383];  // Cell array.
	logic [7:0]  dv;             // Byte the device would drive.
	logic [7:0]  last;           // Last level seen on the data wire.
	logic [7:0]  pd;             // Data latched during a pulse.
	logic [13:0] pa;             // Address latched during a pulse.
	logic        drv;            // Device drives the data wire.
	logic        armed;          // A program pulse is in progress.
	logic        prog;           // Pins form the programming mode.
	logic        slip;           // Contention or unstable inputs.
	int          hits;           // Pulses on the byte since selection.
	int          low_cnt;        // Cycles of the current pulse.

	initial begin
		foreach (mem[i]) mem[i] = 8'hff;  // A fresh array reads ones.
		{pulses, width, bad, hits, low_cnt} = '0;
		{armed, last, pd, pa} = '0;
	end

	assign prog = !pins.chip_on_low && pins.output_on_low && !pins.burn_strobe_n
		&& pins.vpp_raise && pins.vcc_raise;

	// Output path; an undriven wire shows the inverse of its last level, so a
	// sample taken outside the access window cannot pass by luck.
	always_comb begin
		drv = !pins.chip_on_low && !pins.output_on_low && pins.burn_strobe_n;
		if (pins.id_high_volt_pin) begin
			dv = (pins.addr[13:1] == 13'h0) ? (pins.addr[0] ? DEV_ID : MFG_ID) : 8'h00;
		end else if (pins.vcc_raise && !pins.vpp_raise) begin
			dv = 8'h00;  // Supplies out of order give no valid data.
		end else begin
			dv = mem[pins.addr];
		end
		data_in = pins.data_oe ? pins.data_out : (drv ? dv : ~last);
		slip = (pins.data_oe && drv) || (prog && armed && (pins.addr != pa
			|| pins.data_out != pd || !pins.data_oe));
	end

	// Pulse bookkeeping; a byte only takes once enough pulses have landed.
	always @(posedge clk) begin
		last <= data_in;
		bad  <= bad + (slip ? 1 : 0);
		if (pins.chip_on_low) begin
			hits <= 0;
		end
		if (prog) begin
			armed   <= 1'b1;
			pa      <= pins.addr;
			pd      <= pins.data_out;
			low_cnt <= low_cnt + 1;
		end else if (armed) begin
			armed   <= 1'b0;
			width   <= low_cnt;
			low_cnt <= 0;
			pulses  <= pulses + 1;
			hits    <= hits + 1;
			if (!pins.chip_on_low && hits + 1 >= pulse_need) begin
				mem[pa] <= mem[pa] & pd;  // Ones to zeros only.
			end
		end
	end
endmodule

// ---- uvp_ctrl_bench.sv ----
// Self-checking testbench of the memory programmer controller.
`timescale 1ns/1ps
module uvp_ctrl_bench;
	localparam int PSIM = 20;  // Short pulse keeps the run brief.
	localparam int MAXP = uvp_pkg::MAX_PULSES;
	logic               clk = 1'b0;
	logic               resetn = 1'b0;
	logic               ce = 1'b1;
	logic               req_valid = 1'b0;
	logic [1:0]         req_cmd = 2'h0;
	logic [13:0]        req_addr = 14'h0;
	logic [7:0]         req_wdata = 8'h0;
	logic               req_ready;
	uvp_pkg::uvp_resp_t resp;
	uvp_pkg::uvp_pins_t pins;
	logic [7:0]         data_in;
	logic [3:0]         pulse_need = 4'h1;
	int                 pulses, width, bad;
	int                 errors = 0;
	int                 comparisons = 0;
	logic [7:0]         shadow [int];  // Expected array contents.
	logic [13:0]        addrs [6];
	logic [7:0]         rd, cur, w;
	logic               fl;
	int                 i, k, p0, need;

	always #2 clk = ~clk;

	uvp_ctrl #(.PULSE_CYC(PSIM), .MAX_PULSES(MAXP)) uut (.clk(clk), .resetn(resetn), .ce(ce),
		.req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_ready(req_ready), .resp(resp), .pins(pins), .data_in(data_in));
	uvp_eprom_model dev (.clk(clk), .pins(pins), .pulse_need(pulse_need), .data_in(data_in),
		.pulses(pulses), .width(width), .bad(bad));
	// Second device on the same pins, programmed alongside the first.
	uvp_eprom_model dev2 (.clk(clk), .pins(pins), .pulse_need(pulse_need), .data_in(),
		.pulses(), .width(), .bad());

	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task end_sim;
		if (errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// One request: wait for ready, hold valid for one cycle, wait for done bounded.
	task automatic run(input logic [1:0] cmd, input logic [13:0] a, input logic [7:0] wd);
		int n;
		@(posedge clk);
		#1;
		for (n = 0; n < 100 && req_ready !== 1'b1; n++) begin @(posedge clk); #1; end
		{req_valid, req_cmd, req_addr, req_wdata} = {1'b1, cmd, a, wd};
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		for (n = 0; n < 2000 && resp.done !== 1'b1; n++) begin @(posedge clk); #1; end
		chk("done", 1, resp.done);
		rd = resp.rdata;
		fl = resp.fail;
		@(posedge clk);
		#1;
		chk("standby", 32'h8, {pins.chip_on_low, pins.vpp_raise, pins.vcc_raise, pins.data_oe});
	endtask

	// Pulses the controller applies before the readback matches or it gives up after the last pulse.
	function automatic int exp_pulses(logic [7:0] c, logic [7:0] d, int nd);
		if (c == d) return 1;
		if (nd <= MAXP && (c & d) == d) return nd;
		return MAXP;
	endfunction

	function automatic logic exp_fail(logic [7:0] c, logic [7:0] d, int nd);
		return !(c == d || (nd <= MAXP && (c & d) == d));
	endfunction

	// --------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------
	initial begin
		void'($urandom(32'hc83d));
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		chk("reset_pins", 2'h2, {pins.chip_on_low, pins.data_oe});
		for (i = 0; i < 2; i++) begin
			run(2'h2, {14'($urandom) & 14'h3ffe} | 14'(i), 8'h0);
			chk("id_byte", i ? 8'h4e : 8'ha5, rd);
		end
		// A reserved command must be ignored.
		@(posedge clk);
		#1 {req_valid, req_cmd} = 3'h7;
		k = 0;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			#1 k += (resp.done !== 1'b0 || req_ready !== 1'b1);
		end
		req_valid = 1'b0;
		chk("refused", 0, k);
		foreach (addrs[j]) addrs[j] = 14'($urandom);
		run(2'h0, addrs[0], 8'h0);
		chk("blank", 8'hff, rd);
		// Clock enable low freezes a read in progress, which then completes.
		@(posedge clk);
		#1 {req_valid, req_cmd, req_addr} = {1'b1, 2'h0, addrs[0]};
		@(posedge clk);
		#1 {req_valid, ce} = 2'b00;
		k = 0;
		repeat (30) begin
			@(posedge clk);
			#1 k += (resp.done !== 1'b0 || pins.output_on_low !== 1'b0);
		end
		ce = 1'b1;
		for (i = 0; i < 50 && resp.done !== 1'b1; i++) begin @(posedge clk); #1; end
		chk("frozen", 0, k);
		chk("thawed", 32'h1ff, {resp.done, resp.rdata});
		// Edge counts first, then random bytes on a small address set.
		for (i = 0; i < 14; i++) begin
			need = (i == 0) ? 1 : (i == 1) ? 10 : (i == 2) ? 11 : $urandom_range(1, 4);
			k = $urandom_range(0, 5);
			w = $urandom;
			cur = shadow.exists(addrs[k]) ? shadow[addrs[k]] : 8'hff;
			pulse_need = 4'(need);
			p0 = pulses;
			run(2'h1, addrs[k], w);
			chk("fail", exp_fail(cur, w, need), fl);
			chk("pulses", exp_pulses(cur, w, need), pulses - p0);
			chk("width", PSIM, width);
			shadow[addrs[k]] = (need <= exp_pulses(cur, w, need)) ? cur & w : cur;
			run(2'h0, addrs[k], 8'h0);
			chk("readback", shadow[addrs[k]], rd);
		end
		foreach (shadow[a]) begin
			run(2'h0, 14'(a), 8'h0);
			chk("final", shadow[a], rd);
			chk("parallel", shadow[a], dev2.mem[a]);
		end
		chk("pin_faults", 0, bad);
		end_sim;
	end

	// Hang guard, well past the expected run length.
	initial begin
		#200000;
		errors++;
		end_sim;
	end
endmodule
